/* common/dal_map.svh */
// Constants for the drive alarm latch and speed trip block
`ifndef DAL_MAP_SVH
`define DAL_MAP_SVH
`define DAL_NUM_ALARMS 16
`define DAL_SPEED_ALARM 4'h0
`define DAL_USER_ALARM 4'hF
`define DAL_ALWAYS_EN_MASK 16'h83FF
`define DAL_OPT_SHIFT 10
`define DAL_TICK_NS 1000000
`define DAL_CLK_NS 4
`define DAL_BLOCK_MS 10
`define DAL_BLOCK_CYC ((`DAL_BLOCK_MS * 1000000) / `DAL_CLK_NS)
`define DAL_SPD_TRIP_MS 400
`define DAL_SPD_AVF_MS 200
`define DAL_SPD_TRIP_TICKS 16'h0190
`define DAL_SPD_AVF_TICKS 16'h00C8
`define DAL_FULL_SPEED 16'h7FFF
`define DAL_LOW_SPEED_PCT 10
`define DAL_CNT_ZERO 16'h0000
`define DAL_CNT_ONE 16'h0001
`endif

/* common/dal_pkg.sv */
// Types for the drive alarm latch and speed trip block
`default_nettype none
package dal_pkg;
  typedef logic [15:0] dal_vec_type;
  typedef logic [15:0] dal_cnt_type;
  typedef logic [3:0] dal_idx_type;
  typedef enum logic [2:0] {
    DAL_IDLE = 3'b001,
    DAL_TRIPPED = 3'b010,
    DAL_BLOCKED = 3'b100
  } dal_state_type;
endpackage : dal_pkg
`default_nettype wire

/* design/dal_persist.sv */
// Per-alarm persistence counters
`default_nettype none
`include "dal_map.svh"
module dal_persist (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Timing
  input wire logic tick,
  input wire dal_pkg::dal_vec_type cond,
  input wire logic [255:0] delay_ticks,
  // Result
  output dal_pkg::dal_vec_type expired
);
  import dal_pkg::*;
  genvar gi;
  generate
    for (gi = 0; gi < `DAL_NUM_ALARMS; gi++) begin : g_alm
      dal_cnt_type cnt_ff;
      dal_cnt_type dly;
      assign dly = delay_ticks[gi*16 +: 16];
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          cnt_ff <= `DAL_CNT_ZERO;
        end else if (!cond[gi]) begin
          cnt_ff <= `DAL_CNT_ZERO;
        end else if (tick && cnt_ff < dly) begin
          cnt_ff <= cnt_ff + `DAL_CNT_ONE;
        end
      end
      assign expired[gi] = cond[gi] && (cnt_ff >= dly);
    end
  endgenerate
endmodule : dal_persist
`default_nettype wire

/* design/dal_speed_check.sv */
// Speed feedback versus armature voltage comparison
`default_nettype none
`include "dal_map.svh"
module dal_speed_check (
  // Measurements
  input wire logic [15:0] speed_fbk,
  input wire logic [15:0] arm_volt_fbk,
  input wire logic [15:0] speed_mismatch_tolerance,
  // Mode
  input wire logic field_weakening_en,
  input wire logic volt_clamped,
  // Result
  output logic mismatch
);
  logic [15:0] diff;
  logic [31:0] low_lim;
  assign diff = (speed_fbk > arm_volt_fbk) ? speed_fbk - arm_volt_fbk
                                           : arm_volt_fbk - speed_fbk;
  assign low_lim = (32'(`DAL_FULL_SPEED) * `DAL_LOW_SPEED_PCT) / 100;
  always_comb begin
    if (field_weakening_en && volt_clamped) begin
      mismatch = 32'(speed_fbk) < low_lim;
    end else begin
      mismatch = diff > speed_mismatch_tolerance;
    end
  end
endmodule : dal_speed_check
`default_nettype wire

/* design/dal_alarm_top.sv */
// Drive alarm supervision with first-trip capture and speed mismatch fallback
`default_nettype none
`include "dal_map.svh"
module dal_alarm_top (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Timing base
  input wire logic tick,
  // Alarm conditions, slot 0 is speed mismatch, slot 15 is user alarm
  input wire dal_pkg::dal_vec_type alarm_cond,
  input wire logic user_alarm_in,
  input wire logic [5:0] optional_alarm_en,
  input wire logic [255:0] alarm_delay_ticks,
  // Commands
  input wire logic start_cmd,
  input wire logic jog_cmd,
  input wire logic left_key,
  input wire logic external_alarm_clear,
  // Speed feedback configuration
  input wire logic speed_mismatch_trip_en,
  input wire logic [15:0] speed_mismatch_tolerance,
  input wire logic [15:0] speed_fbk,
  input wire logic [15:0] arm_volt_fbk,
  input wire logic field_weakening_en,
  input wire logic volt_clamped,
  input wire logic arm_volt_selected,
  // Retained trip cause from non-volatile store
  input wire logic [3:0] stored_cause,
  // Outputs
  output dal_pkg::dal_vec_type active_alarm_monitor,
  output dal_pkg::dal_vec_type latched_alarm_monitor,
  output dal_pkg::dal_idx_type trip_cause,
  output logic trip_cause_valid,
  output logic trip_message_show,
  output logic shutdown,
  output logic main_contactor,
  output logic drive_start_flag,
  output logic armature_voltage_fallback,
  output logic speed_mismatch_warning
);
  import dal_pkg::*;

  localparam int BLOCK_CYC = `DAL_BLOCK_CYC;

  dal_vec_type cond;
  dal_vec_type expired;
  dal_vec_type enable_mask;
  dal_vec_type latch_set;
  logic mismatch_raw;
  logic spd_cond;
  logic [255:0] delays;
  dal_cnt_type spd_cnt_ff;
  dal_state_type state_ff;
  dal_state_type nxt_state;
  logic [31:0] block_cnt_ff;
  dal_vec_type active_ff;
  dal_vec_type latched_ff;
  dal_idx_type cause_ff;
  logic cause_valid_ff;
  logic show_ff;
  logic shutdown_ff;
  logic contactor_ff;
  logic start_flag_ff;
  logic avf_ff;
  logic warn_ff;
  logic run_req;
  logic run_req_d_ff;
  logic new_start;
  logic stopped_ff;
  logic load_ff;
  logic any_latched;
  logic first_idx_found;
  dal_idx_type first_idx;

  dal_speed_check u_speed (
    .speed_fbk(speed_fbk),
    .arm_volt_fbk(arm_volt_fbk),
    .speed_mismatch_tolerance(speed_mismatch_tolerance),
    .field_weakening_en(field_weakening_en),
    .volt_clamped(volt_clamped),
    .mismatch(mismatch_raw)
  );

  // Mismatch suppressed on armature feedback or while fallback is active
  assign spd_cond = mismatch_raw && !arm_volt_selected && !avf_ff;

  always_comb begin
    cond = alarm_cond;
    cond[`DAL_SPEED_ALARM] = spd_cond;
    cond[`DAL_USER_ALARM] = alarm_cond[`DAL_USER_ALARM] | user_alarm_in;
    delays = alarm_delay_ticks;
    delays[0 +: 16] = `DAL_SPD_TRIP_TICKS;
  end

  // Speed alarm slot 0 gated by its own enable; six others optional (10..14 and user alarm 15)
  always_comb begin
    enable_mask = `DAL_ALWAYS_EN_MASK;
    enable_mask[`DAL_OPT_SHIFT +: 5] = optional_alarm_en[4:0];
    enable_mask[`DAL_SPEED_ALARM] = speed_mismatch_trip_en;
    if (!optional_alarm_en[5]) begin
      enable_mask[`DAL_USER_ALARM] = 1'b0;
    end
  end

  dal_persist u_persist (
    .clock(clock),
    .sys_rst(sys_rst),
    .tick(tick),
    .cond(cond),
    .delay_ticks(delays),
    .expired(expired)
  );

  assign run_req = start_cmd | jog_cmd;
  assign new_start = start_cmd && !run_req_d_ff;
  assign any_latched = |latched_ff;
  assign latch_set = (state_ff == DAL_BLOCKED) ? 16'h0000
                                               : (expired & enable_mask);

  always_comb begin
    first_idx = 4'h0;
    first_idx_found = 1'b0;
    for (int i = 0; i < `DAL_NUM_ALARMS; i++) begin
      if (!first_idx_found && latch_set[i]) begin
        first_idx = 4'(i);
        first_idx_found = 1'b1;
      end
    end
  end

  // Trip state
  always_comb begin
    case (state_ff)
      DAL_IDLE: nxt_state = (|latch_set) ? DAL_TRIPPED : DAL_IDLE;
      DAL_TRIPPED: nxt_state = (block_cnt_ff >= 32'(BLOCK_CYC - 1)) ? DAL_BLOCKED : DAL_TRIPPED;
      DAL_BLOCKED: nxt_state = DAL_BLOCKED;
      default: nxt_state = DAL_IDLE;
    endcase
    if (external_alarm_clear || new_start) begin
      nxt_state = DAL_IDLE;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= DAL_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      block_cnt_ff <= 32'h00000000;
    end else if (state_ff == DAL_TRIPPED) begin
      block_cnt_ff <= block_cnt_ff + 32'h00000001;
    end else begin
      block_cnt_ff <= 32'h00000000;
    end
  end

  // Set wins over clear so a coinciding expiry is not lost
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      latched_ff <= 16'h0000;
    end else if (external_alarm_clear || new_start) begin
      latched_ff <= latch_set;
    end else begin
      latched_ff <= latched_ff | latch_set;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      active_ff <= 16'h0000;
    end else begin
      active_ff <= cond;
    end
  end

  // Retained cause loaded one cycle after reset release
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      load_ff <= 1'b1;
    end else begin
      load_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cause_ff <= 4'h0;
      cause_valid_ff <= 1'b0;
    end else if (load_ff) begin
      cause_ff <= stored_cause;
      cause_valid_ff <= 1'b1;
    end else if (state_ff == DAL_IDLE && |latch_set && !new_start) begin
      cause_ff <= first_idx;
      cause_valid_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      show_ff <= 1'b0;
    end else if (state_ff == DAL_IDLE && |latch_set && !new_start) begin
      show_ff <= 1'b1;
    end else if (left_key || new_start) begin
      show_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      shutdown_ff <= 1'b0;
      contactor_ff <= 1'b0;
      start_flag_ff <= 1'b0;
    end else begin
      shutdown_ff <= any_latched;
      contactor_ff <= run_req && !any_latched;
      start_flag_ff <= start_cmd && !any_latched;
    end
  end

  // Speed mismatch fallback and warning
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      spd_cnt_ff <= `DAL_CNT_ZERO;
    end else if (!spd_cond) begin
      spd_cnt_ff <= `DAL_CNT_ZERO;
    end else if (tick && spd_cnt_ff < `DAL_SPD_TRIP_TICKS) begin
      spd_cnt_ff <= spd_cnt_ff + `DAL_CNT_ONE;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      run_req_d_ff <= 1'b0;
      stopped_ff <= 1'b0;
    end else begin
      run_req_d_ff <= run_req;
      if (!run_req) begin
        stopped_ff <= 1'b1;
      end else if (new_start) begin
        stopped_ff <= 1'b0;
      end
    end
  end

  // Fallback set wins over the restart restore
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      avf_ff <= 1'b0;
    end else if (!speed_mismatch_trip_en && spd_cond &&
                 spd_cnt_ff >= `DAL_SPD_AVF_TICKS) begin
      avf_ff <= 1'b1;
    end else if (new_start && stopped_ff) begin
      avf_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      warn_ff <= 1'b0;
    end else if (spd_cnt_ff >= `DAL_SPD_TRIP_TICKS ||
                 (!speed_mismatch_trip_en && spd_cnt_ff >= `DAL_SPD_AVF_TICKS)) begin
      warn_ff <= 1'b1;
    end else if (!run_req) begin
      warn_ff <= 1'b0;
    end
  end

  assign active_alarm_monitor = active_ff;
  assign latched_alarm_monitor = latched_ff;
  assign trip_cause = cause_ff;
  assign trip_cause_valid = cause_valid_ff;
  assign trip_message_show = show_ff;
  assign shutdown = shutdown_ff;
  assign main_contactor = contactor_ff;
  assign drive_start_flag = start_flag_ff;
  assign armature_voltage_fallback = avf_ff;
  assign speed_mismatch_warning = warn_ff;

  // Assertions
  chk_disabled_no_latch: assert property (@(posedge clock) disable iff (sys_rst)
    (!optional_alarm_en[0] |-> !latch_set[10])) else $error("disabled alarm latched");
  chk_contactor_closes: assert property (@(posedge clock) disable iff (sys_rst)
    (run_req && !any_latched |=> main_contactor)) else $error("contactor open");
  chk_show_on_trip: assert property (@(posedge clock) disable iff (sys_rst)
    (state_ff == DAL_IDLE && |latch_set && !new_start |=> trip_message_show)) else $error("no message");
  chk_avf_restore: assert property (@(posedge clock) disable iff (sys_rst)
    (new_start && stopped_ff && !spd_cond |=> !armature_voltage_fallback)) else $error("no restore");
  chk_latch_shuts_down: assert property (@(posedge clock) disable iff (sys_rst)
    (any_latched |=> shutdown && !main_contactor)) else $error("no shutdown");
  chk_start_flag_low: assert property (@(posedge clock) disable iff (sys_rst)
    (any_latched |=> !drive_start_flag)) else $error("start flag high");
  chk_blocked_no_set: assert property (@(posedge clock) disable iff (sys_rst)
    (state_ff == DAL_BLOCKED |-> latch_set == 16'h0000)) else $error("latched when blocked");
  chk_clear_latches: assert property (@(posedge clock) disable iff (sys_rst)
    (external_alarm_clear |=> latched_alarm_monitor == $past(latch_set))) else $error("not cleared");
  chk_suppress_avsel: assert property (@(posedge clock) disable iff (sys_rst)
    (arm_volt_selected |-> !cond[0])) else $error("mismatch not suppressed");
  chk_first_cause: assert property (@(posedge clock) disable iff (sys_rst)
    (state_ff == DAL_IDLE && |latch_set && !new_start && !load_ff |=> trip_cause == $past(first_idx)))
    else $error("wrong trip cause");
  chk_warn_clear: assert property (@(posedge clock) disable iff (sys_rst)
    (!run_req && spd_cnt_ff < `DAL_SPD_AVF_TICKS |=> !speed_mismatch_warning))
    else $error("warning not cleared");
  chk_avf_no_trip: assert property (@(posedge clock) disable iff (sys_rst)
    (!speed_mismatch_trip_en |-> !latch_set[0])) else $error("speed trip when disabled");
  // Coverage of main scenarios
  cov_trip: cover property (@(posedge clock) disable iff (sys_rst) $rose(shutdown));
  cov_warn: cover property (@(posedge clock) disable iff (sys_rst) $rose(speed_mismatch_warning));
  cov_two_latched: cover property (@(posedge clock) disable iff (sys_rst) latched_ff[3] && latched_ff[5]);
  cov_blocked: cover property (@(posedge clock) disable iff (sys_rst) state_ff == DAL_BLOCKED);
  cov_avf: cover property (@(posedge clock) disable iff (sys_rst) $rose(armature_voltage_fallback));
endmodule : dal_alarm_top
`default_nettype wire

/* tb/tb_dal_alarm_top.sv */
// Self-checking bench for the drive alarm latch and speed trip block
`default_nettype none
module tb_dal_alarm_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dal_pkg::*;

  logic clock, sys_rst, tick, user_alarm_in, start_cmd, jog_cmd, left_key;
  logic external_alarm_clear, speed_mismatch_trip_en, field_weakening_en;
  logic volt_clamped, arm_volt_selected;
  dal_vec_type alarm_cond;
  logic [5:0] optional_alarm_en;
  logic [255:0] alarm_delay_ticks;
  logic [15:0] speed_mismatch_tolerance, speed_fbk, arm_volt_fbk;
  logic [3:0] stored_cause;
  dal_vec_type active_alarm_monitor, latched_alarm_monitor;
  dal_idx_type trip_cause;
  logic trip_cause_valid, trip_message_show, shutdown, main_contactor, drive_start_flag;
  logic armature_voltage_fallback, speed_mismatch_warning;
  int n_mismatch, num_checks, cycles;
  logic [31:0] seed;

  dal_alarm_top dut (
    .clock, .sys_rst, .tick, .alarm_cond, .user_alarm_in, .optional_alarm_en,
    .alarm_delay_ticks, .start_cmd, .jog_cmd, .left_key, .external_alarm_clear,
    .speed_mismatch_trip_en, .speed_mismatch_tolerance, .speed_fbk, .arm_volt_fbk,
    .field_weakening_en, .volt_clamped, .arm_volt_selected, .stored_cause,
    .active_alarm_monitor, .latched_alarm_monitor, .trip_cause, .trip_cause_valid,
    .trip_message_show, .shutdown, .main_contactor, .drive_start_flag,
    .armature_voltage_fallback, .speed_mismatch_warning
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  // Slots 1..9 always armed, 10..14 by their own enable bit
  function automatic bit exp_en(input int k, input logic [5:0] en);
    return (k < 10) || (en[k-10] === 1'b1);
  endfunction : exp_en

  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  task automatic wait_lat(input int k, input int n);
    for (int i = 0; i < n && latched_alarm_monitor[k] !== 1'b1; i++) @(negedge clock);
  endtask : wait_lat

  // Clear latches by a new start or by the external clear
  task automatic clr(input bit by_start);
    if (by_start) begin
      start_cmd = 1'b0;
      cyc(2);
      start_cmd = 1'b1;
    end else begin
      external_alarm_clear = 1'b1;
    end
    cyc(3);
    external_alarm_clear = 1'b0;
    cyc(2);
  endtask : clr

  task automatic report_and_stop;
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Tick on every second cycle, plus the hang limit
  always @(negedge clock) begin
    tick <= ~tick;
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    int k;
    int d;
    bit ok;
    sys_rst = 1'b1;
    tick = 1'b0;
    cycles = 0;
    n_mismatch = 0;
    num_checks = 0;
    seed = 32'h0000000B;
    alarm_cond = 16'h0000;
    user_alarm_in = 1'b0;
    optional_alarm_en = 6'h00;
    alarm_delay_ticks = {16{16'h0003}};
    start_cmd = 1'b1;
    jog_cmd = 1'b0;
    left_key = 1'b0;
    external_alarm_clear = 1'b0;
    speed_mismatch_trip_en = 1'b1;
    speed_mismatch_tolerance = 16'h1333;
    speed_fbk = 16'h2000;
    arm_volt_fbk = 16'h2000;
    field_weakening_en = 1'b0;
    volt_clamped = 1'b0;
    arm_volt_selected = 1'b0;
    stored_cause = 4'h6;
    cyc(1);
    chk(shutdown === 1'b0 && latched_alarm_monitor === 16'h0000, "reset outputs");
    cyc(1);
    sys_rst = 1'b0;
    cyc(3);
    chk(trip_cause === 4'h6 && trip_cause_valid === 1'b1, "retained cause");
    for (int it = 0; it < 14; it++) begin
      seed = xs(seed);
      k = 1 + int'(seed[3:0]) % 14;
      d = 3 + int'(seed[7:4]) % 8;
      optional_alarm_en = seed[13:8];
      alarm_delay_ticks[k*16 +: 16] = d[15:0];
      // Short burst, gap, then hold: count must restart
      alarm_cond[k] = 1'b1;
      cyc(2 * d - 4);
      alarm_cond[k] = 1'b0;
      cyc(2);
      alarm_cond[k] = 1'b1;
      cyc(2 * d - 4);
      chk(latched_alarm_monitor[k] === 1'b0, "latched early");
      chk(active_alarm_monitor[k] === 1'b1, "active monitor");
      wait_lat(k, 12);
      ok = exp_en(k, optional_alarm_en);
      chk(latched_alarm_monitor[k] === ok, "latch vs enable");
      cyc(3);
      chk(shutdown === ok && main_contactor === !ok, "shutdown");
      chk(drive_start_flag === !ok, "start flag");
      if (ok) chk(trip_cause === k[3:0] && trip_message_show === 1'b1, "cause");
      else chk(active_alarm_monitor[k] === 1'b1, "disabled visible");
      alarm_cond[k] = 1'b0;
      clr(it[0]);
      chk(latched_alarm_monitor === 16'h0000 && main_contactor === 1'b1, "clear");
    end
    alarm_cond[3] = 1'b1;
    wait_lat(3, 40);
    alarm_cond[5] = 1'b1;
    wait_lat(5, 40);
    chk(latched_alarm_monitor[5] === 1'b1 && trip_cause === 4'h3, "first cause");
    left_key = 1'b1;
    cyc(2);
    left_key = 1'b0;
    cyc(2);
    chk(trip_message_show === 1'b0, "left key");
    alarm_cond = 16'h0000;
    clr(1'b0);
    optional_alarm_en = 6'h20;
    user_alarm_in = 1'b1;
    wait_lat(15, 40);
    chk(latched_alarm_monitor[15] === 1'b1 && trip_cause === 4'hF, "user alarm");
    user_alarm_in = 1'b0;
    clr(1'b1);
    speed_fbk = 16'h5000;
    cyc(770);
    chk(latched_alarm_monitor[0] === 1'b0, "speed early");
    wait_lat(0, 60);
    chk(latched_alarm_monitor[0] === 1'b1 && trip_cause === 4'h0, "speed trip");
    speed_fbk = 16'h2000;
    clr(1'b0);
    arm_volt_selected = 1'b1;
    speed_fbk = 16'h5000;
    cyc(900);
    chk(latched_alarm_monitor[0] === 1'b0 && shutdown === 1'b0, "suppressed");
    arm_volt_selected = 1'b0;
    speed_mismatch_trip_en = 1'b0;
    cyc(370);
    chk(armature_voltage_fallback === 1'b0, "fallback early");
    for (int i = 0; i < 60 && armature_voltage_fallback !== 1'b1; i++) cyc(1);
    chk(armature_voltage_fallback === 1'b1 && speed_mismatch_warning === 1'b1, "fallback");
    cyc(500);
    chk(latched_alarm_monitor[0] === 1'b0, "tripped while disabled");
    speed_fbk = 16'h2000;
    start_cmd = 1'b0;
    cyc(3);
    chk(speed_mismatch_warning === 1'b0 && armature_voltage_fallback === 1'b1, "stop");
    start_cmd = 1'b1;
    cyc(3);
    chk(armature_voltage_fallback === 1'b0, "restart restores");
    speed_mismatch_trip_en = 1'b1;
    field_weakening_en = 1'b1;
    volt_clamped = 1'b1;
    speed_fbk = 16'h0100;
    arm_volt_fbk = 16'h0100;
    wait_lat(0, 900);
    chk(latched_alarm_monitor[0] === 1'b1, "low speed when clamped");
    report_and_stop();
  end
endmodule : tb_dal_alarm_top
`default_nettype wire
